// *** rtl/desc_dma.sv ***
// Descriptor engine: checks ownership, builds status dword 0, hands descriptor back
//
// How it works
// - TX dword0: length high, owner bit 15
// - Collision count in TX bits 12..8
// - Bit 7 deferring, sticks for jabber
// - Late collision aborts, sets bit 6
// - Heartbeat bit 5, cleared by heartbeat miss
// - Underrun sets TX bit 4
// - Carrier loss sets bit 3, not in FDX
// - Bit 2 collided, not late or excessive
// - Bit 1 not deferred, bit 0 sent
// - Dword2 final, no-FCS, interrupt flags
// - Bit 16 fragment list, 17 order
// - Buffer length bits 15..0 unless fragments
// - Dword3 next pointer, low bits unused
// - Monitor mode suppresses receive writeback until status is read
// - RX dword0: byte count, owner bit 15
// - RX bit 14 header, 13 fragment full
// - RX bit 12 status valid
// - RX bits 6,5,4 disabled, bcast, mcast
// - RX bit 3 missed packet
// - RX bit 2 CRC or MII error
// - RX bit 1 alignment, 0 intact
`timescale 1ns/1ps
module desc_dma
  import desc_dma_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Frame events from the MAC
  input  wire tx_evt_s     tx_evt_i,
  input  wire rx_evt_s     rx_evt_i,
  // Engine outputs
  output logic             done_o,
  output logic             irq_req_o,
  output logic             busy_o
);

  typedef struct packed {
    axil_out_s   bus;
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        rd_pend;
    logic [7:0]  ar_addr;
    logic [4:0]  ctrl;
    logic        err_flag;
    logic        done_flag;
    tx_evt_s     tx_evt;
    rx_evt_s     rx_evt;
    logic [31:0] wb0;
    logic [31:0] rx_status;
    logic [31:0] next_ptr;
    logic        rx_status_read;
    eng_state_e  state;
    logic        done;
    logic        irq_req;
    logic        busy;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic              mem_we;
  logic [MEM_AW-1:0] mem_waddr;
  logic [31:0]       mem_wdata;
  logic [MEM_AW-1:0] mem_raddr;
  logic [31:0]       mem_rdata;

  logic [31:0] d0;
  logic [31:0] d2;
  logic [31:0] d3;

  // Descriptor words are kept in a small memory; dword 2 and dword 3 reads are time shared
  desc_word_mem u_mem (
    .core_clk_i (core_clk_i),
    .we_i       (mem_we),
    .waddr_i    (mem_waddr),
    .wdata_i    (mem_wdata),
    .raddr_i    (mem_raddr),
    .rdata_o    (mem_rdata)
  );

  // Merge byte strobes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Transmit status word from MAC events
  function automatic logic [15:0] tx_status(input tx_evt_s e, input logic fdx);
    logic [15:0] s;
    logic        excess;
    s = 16'h0000;
    excess = e.coll_cnt >= CCNT_MAX;
    s[TX_CCNT_MSB:TX_CCNT_LSB] = e.coll_cnt;
    s[TX_DEFER_BIT] = e.deferred | e.jabber;
    s[TX_OWC_BIT]   = e.late_coll;
    s[TX_HBEAT_BIT] = ~fdx & ~e.hb_coll;
    s[TX_UNDR_BIT]  = e.underrun;
    s[TX_CSL_BIT]   = ~fdx & e.carrier_lost;
    s[TX_COLL_BIT]  = (e.coll_cnt != 5'h00) & ~e.late_coll & ~excess;
    s[TX_NDEF_BIT]  = ~e.deferred & ~e.late_coll & ~excess;
    s[TX_OK_BIT]    = ~e.late_coll & ~excess & ~e.underrun;
    return s;
  endfunction

  // Receive status word from MAC events
  function automatic logic [15:0] rx_status(input rx_evt_s e, input logic mon,
                                            input logic mii);
    logic [15:0] s;
    logic        crc;
    s = 16'h0000;
    crc = ~e.runt & (e.crc_bad | (mii & e.rx_err));
    s[RX_HDR_BIT]   = e.hdr_copy;
    s[RX_FLERR_BIT] = e.frag_full;
    s[RX_NSV_BIT]   = ~(e.hdr_copy | e.frag_full);
    s[RX_DIS_BIT]   = e.rx_disabled;
    s[RX_BCAST_BIT] = e.bcast;
    s[RX_MCAST_BIT] = e.mcast;
    s[RX_MISS_BIT]  = ~crc & (mon | e.overflow);
    s[RX_CRC_BIT]   = crc;
    s[RX_ALN_BIT]   = e.crc_bad & e.odd_bits;
    s[RX_OK_BIT]    = ~crc & ~e.overflow & ~mon & ~e.runt;
    return s;
  endfunction

  // Fields of the loaded descriptor words
  assign d0 = st_reg.wb0;
  assign d2 = mem_rdata;
  assign d3 = mem_rdata;

  // Next-state logic: bus slave and descriptor engine
  always_comb
  begin
    st_next   = st_reg;
    mem_we    = 1'b0;
    mem_waddr = desc_index(st_reg.aw_addr);
    mem_wdata = merge(ZERO32, st_reg.w_data, st_reg.w_strb);
    mem_raddr = desc_index(s_axi_araddr_i);
    st_next.done    = 1'b0;
    st_next.irq_req = 1'b0;

    // Address and data taken independently
    st_next.bus.awready = ~st_reg.aw_held & ~st_reg.bus.bvalid;
    st_next.bus.wready  = ~st_reg.w_held & ~st_reg.bus.bvalid;
    if (s_axi_awvalid_i & st_reg.bus.awready)
    begin
      st_next.aw_held     = 1'b1;
      st_next.aw_addr     = s_axi_awaddr_i;
      st_next.bus.awready = 1'b0;
    end
    if (s_axi_wvalid_i & st_reg.bus.wready)
    begin
      st_next.w_held     = 1'b1;
      st_next.w_data     = s_axi_wdata_i;
      st_next.w_strb     = s_axi_wstrb_i;
      st_next.bus.wready = 1'b0;
    end

    // Commit write once both halves are in
    if (st_reg.aw_held & st_reg.w_held & ~st_reg.bus.bvalid)
    begin
      st_next.aw_held    = 1'b0;
      st_next.w_held     = 1'b0;
      st_next.bus.bvalid = 1'b1;
      st_next.bus.bresp  = RESP_OKAY;
      if (is_desc(st_reg.aw_addr))
      begin
        // Strobed bytes are written over zeros; host fills pointer and flags whole
        mem_we = st_reg.state == ST_IDLE;
      end
      else if (st_reg.aw_addr == REG_CTRL)
        st_next.ctrl = st_reg.w_data[4:0];
      else if (st_reg.aw_addr == REG_STATUS)
      begin
        // Write one to clear; a same-cycle set wins below
        if (st_reg.w_data[1]) st_next.err_flag = 1'b0;
        if (st_reg.w_data[0]) st_next.done_flag = 1'b0;
      end
      else if (st_reg.aw_addr == REG_TXEVT)
        st_next.tx_evt = st_reg.w_data[$bits(tx_evt_s)-1:0];
      else if (st_reg.aw_addr == REG_WB0)
        st_next.wb0 = st_reg.w_data;
      else
        st_next.bus.bresp = RESP_SLVERR;
    end
    if (st_reg.bus.bvalid & s_axi_bready_i)
      st_next.bus.bvalid = 1'b0;

    // Latest MAC events are sampled when no write targets them
    if (!(st_reg.aw_held & st_reg.w_held & (st_reg.aw_addr == REG_TXEVT)))
    begin
      st_next.tx_evt = tx_evt_i;
    end
    st_next.rx_evt = rx_evt_i;

    // Read channel; descriptor words come one cycle late from memory
    st_next.bus.arready = ~st_reg.rd_pend & ~st_reg.bus.rvalid;
    if (s_axi_arvalid_i & st_reg.bus.arready)
    begin
      st_next.bus.arready = 1'b0;
      st_next.rd_pend     = 1'b1;
      st_next.ar_addr     = s_axi_araddr_i;
    end
    if (st_reg.rd_pend)
    begin
      st_next.rd_pend    = 1'b0;
      st_next.bus.rvalid = 1'b1;
      st_next.bus.rresp  = RESP_OKAY;
      unique case (1'b1)
        is_desc(st_reg.ar_addr):          st_next.bus.rdata = mem_rdata;
        st_reg.ar_addr == REG_CTRL:       st_next.bus.rdata = {27'h0, st_reg.ctrl};
        st_reg.ar_addr == REG_STATUS:     st_next.bus.rdata =
                                            {29'h0, busy_o, st_reg.err_flag,
                                             st_reg.done_flag};
        st_reg.ar_addr == REG_TXEVT:      st_next.bus.rdata =
                                            {{(32-$bits(tx_evt_s)){1'b0}}, st_reg.tx_evt};
        st_reg.ar_addr == REG_RXEVT:      st_next.bus.rdata =
                                            {{(32-$bits(rx_evt_s)){1'b0}}, st_reg.rx_evt};
        st_reg.ar_addr == REG_WB0:        st_next.bus.rdata = st_reg.wb0;
        st_reg.ar_addr == REG_RX_STATUS:
        begin
          st_next.bus.rdata = st_reg.rx_status;
          // Reading in monitor mode re-enables receive writeback
          if (st_reg.ctrl[CTL_MON_BIT]) st_next.rx_status_read = 1'b1;
        end
        st_reg.ar_addr == REG_NEXT:       st_next.bus.rdata = st_reg.next_ptr;
        default:
        begin
          st_next.bus.rdata = ZERO32;
          st_next.bus.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bus.rvalid & s_axi_rready_i)
      st_next.bus.rvalid = 1'b0;
    if (~st_reg.ctrl[CTL_MON_BIT])
      st_next.rx_status_read = 1'b0;

    // Descriptor engine
    unique case (st_reg.state)
      ST_IDLE:
      begin
        if (st_reg.ctrl[CTL_GO_BIT])
        begin
          st_next.ctrl[CTL_GO_BIT] = 1'b0;
          st_next.state = ST_CHECK;
          mem_raddr = desc_index(REG_DESC2);
        end
      end
      ST_CHECK:
      begin
        // Only a controller-owned descriptor is worked on
        if (~d0[OWNER_BIT])
        begin
          st_next.err_flag = 1'b1;
          st_next.state    = ST_IDLE;
        end
        else
        begin
          st_next.irq_req = ~st_reg.ctrl[CTL_RXSEL_BIT] & d2[IRQ_AFTER_BIT];
          // Fragment list ignores the buffer length and final flag
          if (~st_reg.ctrl[CTL_RXSEL_BIT] & ~d2[FRAG_BIT])
            st_next.wb0[LEN_MSB:LEN_LSB] = d2[BLEN_MSB:0];
          st_next.state = ST_BUILD;
        end
        mem_raddr = desc_index(REG_DESC3);
      end
      ST_BUILD:
      begin
        st_next.next_ptr = {d3[31:NEXT_LSB], 2'b00};
        if (st_reg.ctrl[CTL_RXSEL_BIT])
        begin
          st_next.rx_status = {16'h0000,
                               rx_status(st_reg.rx_evt, st_reg.ctrl[CTL_MON_BIT],
                                         st_reg.ctrl[CTL_MII_BIT])};
          // Monitor mode leaves the host's dword 0 alone unless status was read
          if (~st_reg.ctrl[CTL_MON_BIT] | st_reg.rx_status_read)
            st_next.wb0 = {st_reg.rx_evt.byte_cnt, st_next.rx_status[15:0]};
        end
        else
        begin
          st_next.wb0[15:0] = tx_status(st_reg.tx_evt, st_reg.ctrl[CTL_FDX_BIT]);
        end
        st_next.state = ST_WRITE;
      end
      ST_WRITE:
      begin
        // Monitor mode holds back receive writeback unless status was read
        if (~(st_reg.ctrl[CTL_RXSEL_BIT] & st_reg.ctrl[CTL_MON_BIT] &
              ~st_reg.rx_status_read))
          st_next.wb0[OWNER_BIT] = 1'b0;
        st_next.done_flag = 1'b1;
        st_next.done      = 1'b1;
        st_next.state     = ST_IDLE;
      end
    endcase
    // Kept as a flop so busy_o needs no decode after the register
    st_next.busy = st_next.state != ST_IDLE;
  end

  // Single state register
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready_o = st_reg.bus.awready;
  assign s_axi_wready_o  = st_reg.bus.wready;
  assign s_axi_bvalid_o  = st_reg.bus.bvalid;
  assign s_axi_bresp_o   = st_reg.bus.bresp;
  assign s_axi_arready_o = st_reg.bus.arready;
  assign s_axi_rvalid_o  = st_reg.bus.rvalid;
  assign s_axi_rdata_o   = st_reg.bus.rdata;
  assign s_axi_rresp_o   = st_reg.bus.rresp;
  assign done_o          = st_reg.done;
  assign irq_req_o       = st_reg.irq_req;
  assign busy_o          = st_reg.busy;

endmodule // desc_dma

// *** rtl/desc_dma_pkg.sv ***
// Package: descriptor field layout, register map and shared types
package desc_dma_pkg;

  // Descriptor dword 0 fields (transmit and receive)
  localparam int LEN_MSB        = 31;
  localparam int LEN_LSB        = 16;
  localparam int OWNER_BIT      = 15;
  // Transmit status positions
  localparam int TX_CCNT_MSB    = 12;
  localparam int TX_CCNT_LSB    = 8;
  localparam int TX_DEFER_BIT   = 7;
  localparam int TX_OWC_BIT     = 6;
  localparam int TX_HBEAT_BIT   = 5;
  localparam int TX_UNDR_BIT    = 4;
  localparam int TX_CSL_BIT     = 3;
  localparam int TX_COLL_BIT    = 2;
  localparam int TX_NDEF_BIT    = 1;
  localparam int TX_OK_BIT      = 0;
  // Receive status positions
  localparam int RX_HDR_BIT     = 14;
  localparam int RX_FLERR_BIT   = 13;
  localparam int RX_NSV_BIT     = 12;
  localparam int RX_DIS_BIT     = 6;
  localparam int RX_BCAST_BIT   = 5;
  localparam int RX_MCAST_BIT   = 4;
  localparam int RX_MISS_BIT    = 3;
  localparam int RX_CRC_BIT     = 2;
  localparam int RX_ALN_BIT     = 1;
  localparam int RX_OK_BIT      = 0;
  // Transmit dword 2 control fields, then the dword 3 pointer LSB
  localparam int FINAL_BIT      = 20;
  localparam int NOFCS_BIT      = 19;
  localparam int IRQ_AFTER_BIT  = 18;
  localparam int ORDER_BIT      = 17;
  localparam int FRAG_BIT       = 16;
  localparam int BLEN_MSB       = 15;
  localparam int NEXT_LSB       = 2;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_DESC0   = 8'h10;
  localparam logic [7:0] REG_DESC1   = 8'h14;
  localparam logic [7:0] REG_DESC2   = 8'h18;
  localparam logic [7:0] REG_DESC3   = 8'h1C;
  localparam logic [7:0] REG_TXEVT   = 8'h20;
  localparam logic [7:0] REG_RXEVT   = 8'h24;
  localparam logic [7:0] REG_WB0     = 8'h28;
  localparam logic [7:0] REG_RX_STATUS = 8'h2C;
  localparam logic [7:0] REG_NEXT    = 8'h30;

  // Control register bit positions
  localparam int CTL_GO_BIT      = 0;
  localparam int CTL_RXSEL_BIT   = 1;
  localparam int CTL_FDX_BIT     = 2;
  localparam int CTL_MON_BIT     = 3;
  localparam int CTL_MII_BIT     = 4;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
  localparam logic [4:0]  CCNT_MAX   = 5'h10;
  localparam int MEM_AW              = 2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_BUILD = 2'b10,
    ST_WRITE = 2'b11
  } eng_state_e;

  // Transmit frame events from the MAC side
  typedef struct packed {
    logic [4:0] coll_cnt;
    logic       deferred;
    logic       jabber;
    logic       late_coll;
    logic       hb_coll;
    logic       underrun;
    logic       carrier_lost;
  } tx_evt_s;

  // Receive frame events from the MAC side
  typedef struct packed {
    logic [15:0] byte_cnt;
    logic        hdr_copy;
    logic        frag_full;
    logic        rx_disabled;
    logic        bcast;
    logic        mcast;
    logic        overflow;
    logic        crc_bad;
    logic        rx_err;
    logic        runt;
    logic        odd_bits;
  } rx_evt_s;

  // AXI4-Lite slave outputs
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_out_s;

  // Decode a register byte address to a memory word index
  function automatic logic [MEM_AW-1:0] desc_index(input logic [7:0] a);
    return a[MEM_AW+1:2];
  endfunction

  // True for descriptor word addresses
  function automatic logic is_desc(input logic [7:0] a);
    return (a >= REG_DESC0) && (a <= REG_DESC3);
  endfunction

endpackage

// *** rtl/desc_word_mem.sv ***
// Four-word descriptor memory with registered read data
`timescale 1ns/1ps
module desc_word_mem
  import desc_dma_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              we_i,
  input  wire logic [MEM_AW-1:0] waddr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [MEM_AW-1:0] raddr_i,
  output logic      [31:0]       rdata_o
);

  logic [31:0] word_mem [0:(1<<MEM_AW)-1];
  logic [31:0] rdata_reg;

  // Write port and registered read port; no reset, software loads it
  always_ff @(posedge core_clk_i)
  begin
    if (we_i)
    begin
      word_mem[waddr_i] <= wdata_i;
    end
    rdata_reg <= word_mem[raddr_i];
  end

  assign rdata_o = rdata_reg;

endmodule // desc_word_mem

// *** testbench/desc_dma_sva.sv ***
// Port-level checker for the descriptor engine
`timescale 1ns/1ps
module desc_dma_sva
(
  input wire logic        core_clk_i,
  input wire logic        rst_b_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        done_o,
  input wire logic        irq_req_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  // Done, busy and both bus responses quiet right after a reset edge
  rst_quiet_a: assert property (disable iff (1'b0)
    !rst_b_i |=> !done_o && !busy_o && !s_axi_bvalid_o && !s_axi_rvalid_o)
    else $error("outputs active after reset");
  // Responses stand until taken; read data comes two cycles after the address is taken
  bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
  rd_latency_a: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##2 s_axi_rvalid_o)
    else $error("read answer late");
  // Hand-back and irq request are single pulses; hand-back comes out of a busy engine
  done_pulse_a: assert property (done_o |=> !done_o) else $error("done too long");
  done_busy_a: assert property (done_o |-> $past(busy_o)) else $error("done while idle");
  busy_bound_a: assert property ($rose(busy_o) |-> ##[1:8] !busy_o)
    else $error("engine stuck busy");
  irq_pulse_a: assert property (irq_req_o |=> !irq_req_o) else $error("irq too long");

  cov_done_c: cover property (done_o);
  cov_irq_c: cover property (irq_req_o);
  cov_read_c: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule // desc_dma_sva

bind desc_dma desc_dma_sva u_sva (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
  .done_o(done_o), .irq_req_o(irq_req_o), .busy_o(busy_o));

// *** testbench/mac_evt_model.sv ***
// Behavioural MAC event source giving per-frame transmit and receive outcomes
`timescale 1ns/1ps
module mac_evt_model
  import desc_dma_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic [2:0] scen_i,
  output tx_evt_s         tx_evt_o,
  output rx_evt_s         rx_evt_o
);
  // Levels held for a whole frame; changed only between frames by the bench
  always_ff @(posedge core_clk_i)
  begin
    tx_evt_o <= 11'h000;
    rx_evt_o <= 26'h0000000;
    case (scen_i)
      3'h1: tx_evt_o <= 11'h0E0; // Three collisions after deferral
      3'h2: tx_evt_o <= 11'h04D; // Late collision, heartbeat miss, carrier lost
      3'h3: tx_evt_o <= 11'h412; // Sixteen collisions, jabber, underrun
      3'h4: rx_evt_o <= 26'h0010040; // Clean broadcast frame
      3'h5: rx_evt_o <= 26'h0010029; // Multicast, bad CRC, odd bit count
      3'h6: rx_evt_o <= 26'h001000A; // Runt with bad CRC
      3'h7: rx_evt_o <= 26'h0010004; // Receive error flagged on the MII
      default: ;
    endcase
  end
endmodule // mac_evt_model

// *** testbench/tb_ethernet_descriptor_dma.sv ***
// Testbench: descriptor hand-over, status build and register bus
`timescale 1ns/1ps
module tb_ethernet_descriptor_dma
  import desc_dma_pkg::*;
;
  logic core_clk = 1'b0, rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, wb, v, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, done, irq, busy;
  logic [1:0] bresp, rresp, last_resp;
  logic [2:0] scen = 3'h0;
  tx_evt_s tx_evt;
  rx_evt_s rx_evt;
  int n_errors = 0, checks_done = 0, n_done = 0, n_irq = 0, d0, i0;

  initial forever #2.5 core_clk = ~core_clk;

  mac_evt_model model (.core_clk_i(core_clk), .scen_i(scen), .tx_evt_o(tx_evt),
    .rx_evt_o(rx_evt));
  desc_dma dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .tx_evt_i(tx_evt), .rx_evt_i(rx_evt), .done_o(done),
    .irq_req_o(irq), .busy_o(busy));

  // Pulses are counted in the background; writes may still be finishing
  always @(posedge core_clk)
  begin
    n_done += (done === 1'b1);
    n_irq += (irq === 1'b1);
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, g, m);
    checks_done++;
    if ((g & m) !== (e & m))
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, g);
    chk_word(nm, {31'h0, e}, {31'h0, g}, 32'h1);
  endtask

  // Address and data offered together; each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge core_clk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    last_resp = bresp;
    bready <= 1'b0;
    // Let an edge pass so a following call never reassigns bready at once
    @(posedge core_clk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge core_clk);
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  // Host side: descriptor handed to the engine, then status fetched back
  task automatic run_frame(input logic [31:0] w0, w2, input logic [4:0] ctl,
                           input logic [2:0] sc);
    scen <= sc;
    axi_write(REG_WB0, w0);
    axi_write(REG_DESC1, 32'h0000_2003);
    axi_write(REG_DESC2, w2);
    axi_write(REG_DESC3, 32'h0000_1237);
    d0 = n_done;
    i0 = n_irq;
    axi_write(REG_CTRL, {27'h0, ctl});
    repeat (30) @(posedge core_clk);
    axi_read(REG_WB0, wb);
  endtask

  function automatic logic [31:0] exp_tx(input tx_evt_s e, input logic fdx,
                                         input logic [15:0] n);
    logic ok;
    ok = !e.late_coll && (e.coll_cnt < CCNT_MAX);
    return {n, 3'h0, e.coll_cnt, e.deferred | e.jabber, e.late_coll, !fdx && !e.hb_coll,
            e.underrun, e.carrier_lost && !fdx, ok && (e.coll_cnt != 5'h00),
            ok && !e.deferred, ok};
  endfunction

  function automatic logic [31:0] exp_rx(input rx_evt_s e, input logic mii);
    logic crc;
    crc = (e.crc_bad || (mii && e.rx_err)) && !e.runt;
    return {e.byte_cnt, 1'b0, e.hdr_copy, e.frag_full, !(e.hdr_copy | e.frag_full), 5'h00,
            e.rx_disabled, e.bcast, e.mcast, e.overflow, crc, crc && e.odd_bits,
            !crc && !e.overflow};
  endfunction

  // Every transmit outcome, the late-collision one again in full duplex
  task automatic t_tx();
    for (int k = 0; k < 5; k++)
    begin
      run_frame(32'h0123_8000, (k == 0) ? 32'h0014_0040 : 32'h0009_0040,
                {2'b00, k == 4, 2'b01}, (k == 4) ? 3'h2 : k[2:0]);
      // Single-buffer frames report their buffer length in dword 0
      v = exp_tx(tx_evt, k == 4, (k == 0) ? 16'h0040 : 16'h0123);
      chk_word("tx_status", v, wb, 32'hFFFF_FFFF);
      chk_bit("tx_done", 1'b1, n_done != d0);
      chk_bit("tx_irq", k == 0, n_irq != i0);
    end
    axi_read(REG_NEXT, v);
    chk_word("next_ptr", 32'h0000_1234, v, 32'hFFFF_FFFC);
  endtask

  // Receive outcomes, the last in MII mode; runt acceptance bits left to the design
  task automatic t_rx();
    for (int k = 0; k < 4; k++)
    begin
      run_frame(32'h0000_8000, 32'h0, (k == 3) ? 5'h13 : 5'h03,
                (k == 3) ? 3'h7 : 3'h4 + k[2:0]);
      v = exp_rx(rx_evt, k == 3);
      chk_word("rx_length", v, wb, 32'hFFFF_8000);
      chk_word("rx_bits", v, wb, {17'h0, 13'h1FFF, {2{k != 2}}});
    end
  endtask

  // Monitor mode before a status read, and unowned descriptor: nothing written back
  task automatic t_hold();
    run_frame(32'h0000_8000, 32'h0, 5'h0B, 3'h4);
    chk_word("monitor_wb", 32'h0000_8000, wb, 32'hFFFF_FFFF);
    // Status read while monitoring lets the next frame be written back
    axi_read(REG_RX_STATUS, v);
    run_frame(32'h0000_8000, 32'h0, 5'h0B, 3'h4);
    chk_bit("monitor_read_wb", 1'b0, wb[OWNER_BIT]);
    run_frame(32'h0055_0000, 32'h0, 5'h01, 3'h0);
    chk_word("unowned_wb", 32'h0055_0000, wb, 32'hFFFF_FFFF);
    axi_read(REG_STATUS, v);
    chk_bit("owner_err", 1'b1, v[1]);
    axi_write(REG_STATUS, 32'h0000_0003);
    axi_read(REG_STATUS, v);
    chk_bit("owner_err_clr", 1'b0, v[1]);
  endtask

  task automatic t_unmapped();
    axi_read(8'h40, v);
    chk_word("unmapped_data", 32'h0, v, 32'hFFFF_FFFF);
    chk_word("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, last_resp}, 32'h3);
  endtask

  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_unmapped();
    t_tx();
    t_rx();
    t_hold();
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    tally_and_finish();
  end
endmodule // tb_ethernet_descriptor_dma
